// >>> inc/sdac_pkg.sv
package sdac_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] HALF_SCALE_CODE = 16'h8000;
  localparam logic [15:0] FULL_SCALE_CODE = 16'hffff;
  localparam int SYS_CLK_HZ = 10000000;
  localparam int CLEAR_MIN_NS = 200;
  localparam int CLEAR_MIN_CYC = (CLEAR_MIN_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic inputEnableN;
    logic convEnableN;
    logic zeroAllN;
    logic serialData;
    logic strobeN;
  } sdac_pins_s;

  typedef enum logic [1:0] {
    SDAC_IDLE,
    SDAC_LOW
  } sdac_strobe_e;
endpackage

// >>> rtl/sdac_word_buffer.sv
`timescale 1ns/1ps
module sdac_word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr;
  logic [PW-1:0]    rdPtr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge sys_clk) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clkEn && flush)) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= bump(wrPtr);
      end
      if (pop) begin
        rdPtr <= bump(rdPtr);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// >>> rtl/sdac_front_end.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Input latch feeds separate conversion latch.
// - All control inputs active when low.
// - Latches load on strobe rise while enabled, hold otherwise.
// - Clear zeroes both latches at once.
// - Conversion code is plain unsigned binary.
// - Serial word shifts in MSB first.
// - Strobe shifts bit whenever input enabled, unless clear active.
// - Conversion enable with strobe loads latch.
// - Input latch top bit drives cascade output.
module sdac_front_end (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  input  wire sdac_pkg::sdac_pins_s pins,
  output logic                   cascade_serial_out,
  output logic [15:0]            unsigned_binary_coding,
  output logic [15:0]            wordData,
  output logic                   wordValid,
  input  wire logic              wordReady,
  output logic                   wordDropped
);
  import sdac_pkg::*;

  sdac_pins_s        syncA;
  sdac_pins_s        syncB;
  sdac_strobe_e      strobeState;
  logic [WORD_W-1:0] inputLatch;
  logic [WORD_W-1:0] convLatch;
  logic              riseEdge;
  logic              loadConv;
  logic              clearNow;
  logic              bufReady;
  logic              convTouched;

  // The shifted word is needed by both latches in the two-wire case.
  function automatic logic [WORD_W-1:0] shifted(input logic [WORD_W-1:0] word,
                                                input logic              bitIn);
    shifted = {word[WORD_W-2:0], bitIn};
  endfunction

  // Every pin is asynchronous to sys_clk, so all pass two flops first.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncA <= '1;
      syncB <= '1;
    end else if (clkEn) begin
      syncA <= pins;
      syncB <= syncA;
    end
  end

  assign clearNow = !syncB.zeroAllN;
  assign riseEdge = (strobeState == SDAC_LOW) && syncB.strobeN;
  assign loadConv = riseEdge && !syncB.convEnableN && !clearNow;

  // A full low-then-high excursion is needed; the synchronizers reset high, so a strobe already low at reset still counts on its rise.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strobeState <= SDAC_IDLE;
    end else if (clkEn) begin
      case (strobeState)
        SDAC_IDLE: begin
          if (!syncB.strobeN) begin
            strobeState <= SDAC_LOW;
          end
        end
        SDAC_LOW: begin
          if (syncB.strobeN) begin
            strobeState <= SDAC_IDLE;
          end
        end
        default: strobeState <= SDAC_IDLE;
      endcase
    end
  end

  // Apart from clear, input latch only changes on a completed strobe while its enable is low.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      inputLatch <= ZERO_CODE;
    end else if (clkEn) begin
      if (clearNow) begin
        inputLatch <= ZERO_CODE;
      end else if (riseEdge && !syncB.inputEnableN) begin
        inputLatch <= shifted(inputLatch, syncB.serialData);
      end
    end
  end

  // With both enables low the new word moves through in the same strobe.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      convLatch <= ZERO_CODE;
    end else if (clkEn) begin
      if (clearNow) begin
        convLatch <= ZERO_CODE;
      end else if (loadConv) begin
        convLatch <= syncB.inputEnableN ? inputLatch
                     : shifted(inputLatch, syncB.serialData);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      convTouched <= 1'b0;
      wordDropped <= 1'b0;
    end else if (clkEn) begin
      convTouched <= loadConv || clearNow;
      wordDropped <= (loadConv || clearNow) && !bufReady;
    end
  end

  assign cascade_serial_out     = inputLatch[WORD_W-1];
  assign unsigned_binary_coding = convLatch;

  // The buffer hands each new conversion code to the analog side; a stall
  // of up to two words loses nothing.
  sdac_word_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .clkEn    (clkEn),
    .flush    (1'b0),
    .inData   (convLatch),
    .inValid  (convTouched),
    .inReady  (bufReady),
    .outData  (wordData),
    .outValid (wordValid),
    .outReady (wordReady)
  );
endmodule

// >>> sim/sdac_front_end_properties.sv
`timescale 1ns/1ps
module sdac_front_end_properties (
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire sdac_pkg::sdac_pins_s pins,
  input wire logic                 cascade_serial_out,
  input wire logic [15:0]          unsigned_binary_coding,
  input wire logic [15:0]          wordData,
  input wire logic                 wordValid,
  input wire logic                 wordReady,
  input wire logic                 wordDropped
);
  import sdac_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property ($past(sys_rst) |-> !wordValid && unsigned_binary_coding == 16'h0)
    else $error("busy after reset");
  a_clear_zeroes: assert property (
    !pins.zeroAllN [*5] |-> {cascade_serial_out, unsigned_binary_coding} == 17'h0)
    else $error("clear missed");
  a_conv_holds: assert property (
    (pins.convEnableN && pins.zeroAllN) [*8] |=> $stable(unsigned_binary_coding))
    else $error("conv latch moved");
  a_input_holds: assert property (
    (pins.inputEnableN && pins.zeroAllN) [*8] |=> $stable(cascade_serial_out))
    else $error("input latch moved");
  a_idle_strobe: assert property (
    (pins.strobeN && pins.zeroAllN) [*8] |=> $stable({cascade_serial_out, unsigned_binary_coding}))
    else $error("moved without strobe");
  a_load_pushes: assert property ($changed(unsigned_binary_coding) |-> ##[0:1] wordValid)
    else $error("load not buffered");
  a_head_holds: assert property (wordValid && !wordReady |=> wordValid && $stable(wordData))
    else $error("head lost");
  a_drop_full: assert property (wordDropped |-> $past(wordValid))
    else $error("drop while empty");
endmodule
bind sdac_front_end sdac_front_end_properties sdac_front_end_properties_inst (.*);

// >>> sim/sdac_host_model.sv
`timescale 1ns/1ps
module sdac_host_model (
  output sdac_pkg::sdac_pins_s pins
);
  import sdac_pkg::*;
  initial pins = '1;
  // Data and enables lead the strobe fall by 200 ns and hold 200 ns past its rise.
  task automatic pulse(input logic [2:0] v);
    {pins.inputEnableN, pins.convEnableN, pins.serialData} = v;
    #200 pins.strobeN = 1'h0;
    #400 pins.strobeN = 1'h1;
    #200;
  endtask
  task automatic send(input logic [15:0] w, input logic ld);
    for (int i = 15; i >= 0; i--) pulse({2'h1, w[i]});
    if (ld) pulse({2'h2, w[0]});
    pins = {3'h7, !w[0], 1'h1};
  endtask
  task automatic clear();
    pins.zeroAllN = 1'h0;
    #700 pins.zeroAllN = 1'h1;
    #300;
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %0t %h", $time, g); end end
module tb;
  logic                 sys_clk = 1'h0, sys_rst = 1'h1, wordReady = 1'h1;
  logic                 cascade_serial_out, wordValid, wordDropped;
  logic [15:0]          unsigned_binary_coding, wordData, q [5];
  sdac_pkg::sdac_pins_s pins;
  int                   num_errors = 0, checks_done = 0, seed = 83986, drops = 0;
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) drops += int'(wordDropped === 1'h1);
  sdac_host_model host (.pins);
  sdac_front_end sdac_front_end_inst (.sys_clk, .sys_rst, .clkEn(1'h1), .pins, .cascade_serial_out,
    .unsigned_binary_coding, .wordData, .wordValid, .wordReady, .wordDropped);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'h0;
    // Loads 0 and 1 straddle the half-scale carry; later loads stall the reader to overflow.
    for (int i = 0; i < 5; i++) begin
      q[i] = (i < 2) ? {i[0], {15{!i[0]}}} : 16'($random(seed));
      wordReady = i < 2;
      host.send(q[i], 1'h1);
      repeat (4) @(negedge sys_clk);
      `CHK({cascade_serial_out, unsigned_binary_coding}, {q[i][15], q[i]})
    end
    `CHK(drops, 1)
    for (int i = 2; i < 4; i++) begin
      `CHK({wordValid, wordData}, {1'h1, q[i]})
      wordReady = 1'h1;
      @(negedge sys_clk);
      wordReady = 1'h0;
    end
    $display("load test done");
    host.send(~q[4], 1'h0);
    repeat (4) @(negedge sys_clk);
    `CHK({cascade_serial_out, unsigned_binary_coding}, {!q[4][15], q[4]})
    host.clear();
    `CHK({cascade_serial_out, unsigned_binary_coding}, 17'h0)
    $display("clear test done");
    report_and_stop();
  end
endmodule
